// [common/mfpm_pkg.sv]
// mfpm_pkg: function codes, bit positions and carriers of the multifunction pin map
package mfpm_pkg;
  localparam int CODE_W = 8;
  localparam int DIR_BIT = 7;
  localparam int WDOG_STROBE_CYCLES = 32;
  localparam logic [7:0] OUT_WDOG = 8'h83;
  localparam logic [7:0] OUT_L1_FR = 8'hD5, OUT_L1_HO = 8'hD6, OUT_L1_SW = 8'hD7, OUT_L1_HA = 8'hD8;
  localparam logic [7:0] OUT_L1_HU = 8'hD9, OUT_L1_CL = 8'hDA, OUT_L1_SL = 8'hDB, OUT_L1_SY = 8'hDC;
  localparam logic [7:0] OUT_L1_DM = 8'hDD;
  localparam logic [7:0] OUT_L2_PL = 8'hE0, OUT_L2_FL = 8'hE1, OUT_L2_AL = 8'hE2, OUT_L2_CB = 8'hE3;
  localparam logic [7:0] OUT_L2_AC = 8'hE4, OUT_L2_FR = 8'hE5, OUT_L2_HO = 8'hE6, OUT_L2_SW = 8'hE7;
  localparam logic [7:0] OUT_L2_HA = 8'hE8, OUT_L2_HU = 8'hE9, OUT_L2_CL = 8'hEA, OUT_L2_SL = 8'hEB;
  localparam logic [7:0] OUT_L2_SY = 8'hEC, OUT_L2_DM = 8'hED;
  localparam logic [7:0] OUT_L3_PL = 8'hF0, OUT_L3_FL = 8'hF1, OUT_L3_AL = 8'hF2, OUT_L3_CB = 8'hF3;
  localparam logic [7:0] OUT_L3_AC = 8'hF4, OUT_L3_FR = 8'hF5, OUT_L3_HO = 8'hF6, OUT_L3_SW = 8'hF7;
  localparam logic [7:0] OUT_L3_HA = 8'hF8, OUT_L3_HU = 8'hF9, OUT_L3_CL = 8'hFA, OUT_L3_SL = 8'hFB;
  localparam logic [7:0] OUT_L3_SY = 8'hFC, OUT_L3_DM = 8'hFD, OUT_RSVD = 8'hFE;
  localparam logic [7:0] IN_NONE = 8'h00, IN_IO_UPD = 8'h01, IN_FULL_PD = 8'h02, IN_WDOG_CLR = 8'h03;
  localparam logic [7:0] IN_SYNC_ALL = 8'h04, IN_IRQ_CLR0 = 8'h10, IN_IRQ_CLR5 = 8'h15;
  localparam logic [7:0] IN_FAULT_A = 8'h20, IN_FAULT_D = 8'h23, IN_TMO_A = 8'h28, IN_TMO_D = 8'h2B;
  localparam logic [7:0] IN_L0_PD = 8'h40, IN_L0_FR = 8'h41, IN_L0_HO = 8'h42, IN_L0_HR = 8'h43;
  localparam logic [7:0] IN_L0_INC = 8'h44, IN_L0_DEC = 8'h45, IN_L0_PRST = 8'h46, IN_A0_SYNC = 8'h48;
  localparam int BIT_FR = 0, BIT_HO = 1, BIT_SW = 2;
  localparam int BIT_HA = 0, BIT_CL = 1, BIT_SL = 2, BIT_DM13 = 3, BIT_DM2 = 4;
  localparam int BIT_PL = 1, BIT_FL = 2, BIT_AL = 3, BIT_CB = 4;
  localparam int BIT_HU = 4, BIT_ACT_L2 = 6, BIT_ACT_L3 = 7;

  typedef struct packed {
    logic [3:0][7:0] ref_status;
    logic [7:0] hist_evt_a;
    logic [7:0] hist_evt_b;
    logic [7:0] l1_mode;
    logic [7:0] l1_hist;
    logic [7:0] l2_lock;
    logic [7:0] l2_mode;
    logic [7:0] l2_hist;
    logic [7:0] l3_lock;
    logic [7:0] l3_mode;
    logic [7:0] l3_hist;
    logic [3:1] dist_sync;
    logic wdog_expire;
  } mfpm_status_t;

  typedef struct packed {
    logic io_update;
    logic full_power_down;
    logic wdog_clear;
    logic soft_sync_all;
    logic [5:0] irq_clear;
    logic [3:0] force_fault;
    logic [3:0] force_timeout;
    logic loop0_power_down;
    logic loop0_freerun;
    logic loop0_holdover;
    logic loop0_hist_reset;
    logic loop0_phase_inc;
    logic loop0_phase_dec;
    logic loop0_phase_reset;
    logic analog0_soft_sync;
  } mfpm_ctrl_t;

  localparam mfpm_ctrl_t CTRL_RESET = '0;
endpackage

// [hw/mfpm_sync.sv]
// mfpm_sync: two-stage pin synchroniser with rising edge detect
`timescale 1ns/1ps
module mfpm_sync #(
  parameter int WIDTH = 4
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] rise_o
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;
  } mfpm_sync_state_t;

  mfpm_sync_state_t state;
  mfpm_sync_state_t next_state;

  always_comb begin
    next_state.meta = pin_i;
    next_state.sync = state.meta;
    next_state.prev = state.sync;
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // edge only, so a held pin acts once
  assign rise_o = state.sync & ~state.prev;

  a_rise_single:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
      rise_o[0] |=> !rise_o[0])
    else $error("pin edge lasted more than one cycle");
endmodule

// [hw/mfpm_strobe.sv]
// mfpm_strobe: stretches an expiry pulse into a fixed-length strobe
`timescale 1ns/1ps
module mfpm_strobe #(
  parameter int CYCLES = 32
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic trig_i,
  output logic level_o
);
  localparam int CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic level;
    logic [7:0] run;
  } mfpm_strobe_state_t;

  mfpm_strobe_state_t state;
  mfpm_strobe_state_t next_state;

  always_comb begin
    next_state = state;
    // a new expiry restarts the full length
    if (trig_i) begin
      next_state.cnt = CW'(CYCLES);
    end else if (state.cnt != '0) begin
      next_state.cnt = state.cnt - CW'(1);
    end
    next_state.level = (next_state.cnt != '0);
    // length seen so far, only read by the check below
    next_state.run = trig_i ? 8'h00 : (state.level ? state.run + 8'h01 : 8'h00);
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign level_o = state.level;

  a_strobe_length:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
      $fell(level_o) |-> (state.run == 8'(CYCLES)))
    else $error("strobe length differs from its count");
endmodule

// [hw/mfpm_top.sv]
// mfpm_top: multifunction pin code decode to status outputs and control pulses
// Contract
// - code bit 7 low selects an input function, high an output function.
// - codes D5-D7 drive loop 1 free-run, holdover, switchover flags.
// - code D9 drives loop 1 history-updated event, interrupt enable not needed.
// - codes D8, DA, DB, DD drive loop 1 history, clamp, slew, demap clamp.
// - codes DC, EC, FC drive loop 1, 2, 3 distribution sync pulse directly.
// - codes E0-E3 drive loop 2 phase, frequency, analog lock and calibration busy.
// - code E4 drives OR of reference status bit 6, loop 2 active.
// - codes E5-E7 drive loop 2 free-run, holdover, switchover flags.
// - codes E8, EA, EB, ED drive loop 2 history, clamp, slew, demap clamp.
// - codes F0-F3 drive loop 3 phase, frequency, analog lock and calibration busy.
// - code F4 drives OR of reference status bit 7, loop 3 active.
// - codes F5-F7 and F8, FA, FB, FD drive loop 3 mode and history flags.
// - input code 01 makes the pin a register update strobe; 00 does nothing.
// - input code 03 makes the pin clear the watchdog timer.
// - input codes 28-2B force validation timeout on references a to d.
// - input codes 41 and 42 force loop 0 user free-run and holdover.
// - input code 43 resets the loop 0 tuning word history.
// - input codes 44-46 increment, decrement or reset the loop 0 phase offset.
// - output code 83 gives a strobe that ends 32 cycles after the latest watchdog expiry.
`timescale 1ns/1ps
module mfpm_top #(
  parameter int N = 4
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [N-1:0][mfpm_pkg::CODE_W-1:0] pin_code_i,
  input wire logic [N-1:0] pin_i,
  input wire mfpm_pkg::mfpm_status_t status_i,
  output logic [N-1:0] pin_o,
  output logic [N-1:0] pin_oe_o,
  output mfpm_pkg::mfpm_ctrl_t ctrl_o
);
  import mfpm_pkg::*;

  typedef struct packed {
    logic [N-1:0] pin_out;
    logic [N-1:0] pin_oe;
    mfpm_ctrl_t ctrl;
  } mfpm_state_t;

  mfpm_state_t state;
  mfpm_state_t next_state;
  logic [N-1:0] rise;
  logic wdog_level;

  function automatic logic is_output(input logic [CODE_W-1:0] code);
    return code[DIR_BIT];
  endfunction

  function automatic logic ref_any(input mfpm_status_t st, input int b);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 4; i++) begin
      r = r | st.ref_status[i][b];
    end
    return r;
  endfunction

  function automatic logic out_sel(
    input logic [CODE_W-1:0] code,
    input mfpm_status_t st,
    input logic wdog
  );
    logic r;
    r = 1'b0;
    case (code)
      OUT_WDOG: r = wdog;
      OUT_L1_FR: r = st.l1_mode[BIT_FR];
      OUT_L1_HO: r = st.l1_mode[BIT_HO];
      OUT_L1_SW: r = st.l1_mode[BIT_SW];
      OUT_L1_HA: r = st.l1_hist[BIT_HA];
      OUT_L1_HU: r = st.hist_evt_b[BIT_HU];
      OUT_L1_CL: r = st.l1_hist[BIT_CL];
      OUT_L1_SL: r = st.l1_hist[BIT_SL];
      OUT_L1_SY: r = st.dist_sync[1];
      OUT_L1_DM: r = st.l1_hist[BIT_DM13];
      OUT_L2_PL: r = st.l2_lock[BIT_PL];
      OUT_L2_FL: r = st.l2_lock[BIT_FL];
      OUT_L2_AL: r = st.l2_lock[BIT_AL];
      OUT_L2_CB: r = st.l2_lock[BIT_CB];
      OUT_L2_AC: r = ref_any(st, BIT_ACT_L2);
      OUT_L2_FR: r = st.l2_mode[BIT_FR];
      OUT_L2_HO: r = st.l2_mode[BIT_HO];
      OUT_L2_SW: r = st.l2_mode[BIT_SW];
      OUT_L2_HA: r = st.l2_hist[BIT_HA];
      OUT_L2_HU: r = st.hist_evt_a[BIT_HU];
      OUT_L2_CL: r = st.l2_hist[BIT_CL];
      OUT_L2_SL: r = st.l2_hist[BIT_SL];
      OUT_L2_SY: r = st.dist_sync[2];
      OUT_L2_DM: r = st.l2_hist[BIT_DM2];
      OUT_L3_PL: r = st.l3_lock[BIT_PL];
      OUT_L3_FL: r = st.l3_lock[BIT_FL];
      OUT_L3_AL: r = st.l3_lock[BIT_AL];
      OUT_L3_CB: r = st.l3_lock[BIT_CB];
      OUT_L3_AC: r = ref_any(st, BIT_ACT_L3);
      OUT_L3_FR: r = st.l3_mode[BIT_FR];
      OUT_L3_HO: r = st.l3_mode[BIT_HO];
      OUT_L3_SW: r = st.l3_mode[BIT_SW];
      OUT_L3_HA: r = st.l3_hist[BIT_HA];
      OUT_L3_HU: r = st.hist_evt_b[BIT_HU];
      OUT_L3_CL: r = st.l3_hist[BIT_CL];
      OUT_L3_SL: r = st.l3_hist[BIT_SL];
      OUT_L3_SY: r = st.dist_sync[3];
      OUT_L3_DM: r = st.l3_hist[BIT_DM13];
      // codes owned by other blocks and reserved ones stay low
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic mfpm_ctrl_t in_map(input logic [CODE_W-1:0] code);
    mfpm_ctrl_t c;
    logic [CODE_W-1:0] off;
    c = CTRL_RESET;
    off = '0;
    if (!is_output(code)) begin
      case (code)
        IN_NONE: c = CTRL_RESET;
        IN_IO_UPD: c.io_update = 1'b1;
        IN_FULL_PD: c.full_power_down = 1'b1;
        IN_WDOG_CLR: c.wdog_clear = 1'b1;
        IN_SYNC_ALL: c.soft_sync_all = 1'b1;
        IN_L0_PD: c.loop0_power_down = 1'b1;
        IN_L0_FR: c.loop0_freerun = 1'b1;
        IN_L0_HO: c.loop0_holdover = 1'b1;
        IN_L0_HR: c.loop0_hist_reset = 1'b1;
        IN_L0_INC: c.loop0_phase_inc = 1'b1;
        IN_L0_DEC: c.loop0_phase_dec = 1'b1;
        IN_L0_PRST: c.loop0_phase_reset = 1'b1;
        IN_A0_SYNC: c.analog0_soft_sync = 1'b1;
        default: begin
          if (code >= IN_IRQ_CLR0 && code <= IN_IRQ_CLR5) begin
            off = code - IN_IRQ_CLR0;
            c.irq_clear[off[2:0]] = 1'b1;
          end else if (code >= IN_FAULT_A && code <= IN_FAULT_D) begin
            off = code - IN_FAULT_A;
            c.force_fault[2'(3 - off[1:0])] = 1'b1;
          end else if (code >= IN_TMO_A && code <= IN_TMO_D) begin
            // reference a lands on the highest bit
            off = code - IN_TMO_A;
            c.force_timeout[2'(3 - off[1:0])] = 1'b1;
          end
          // any other input code is ignored
        end
      endcase
    end
    return c;
  endfunction

  mfpm_sync #(
    .WIDTH(N)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .pin_i(pin_i),
    .rise_o(rise)
  );

  mfpm_strobe #(
    .CYCLES(WDOG_STROBE_CYCLES)
  ) u_wdog (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .trig_i(status_i.wdog_expire),
    .level_o(wdog_level)
  );

  always_comb begin
    next_state = state;
    next_state.ctrl = CTRL_RESET;
    for (int p = 0; p < N; p++) begin
      next_state.pin_oe[p] = is_output(pin_code_i[p]);
      next_state.pin_out[p] = is_output(pin_code_i[p]) && out_sel(pin_code_i[p], status_i, wdog_level);
      // several pins on one code merge into one pulse
      if (rise[p]) begin
        next_state.ctrl = mfpm_ctrl_t'(next_state.ctrl | in_map(pin_code_i[p]));
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pin_o = state.pin_out;
  assign pin_oe_o = state.pin_oe;
  assign ctrl_o = state.ctrl;

  a_oe_dir_sel:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
      1'b1 |=> (pin_oe_o[0] == $past(pin_code_i[0][DIR_BIT])))
    else $error("pin enable does not follow direction bit");

  a_l1_mode:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (pin_code_i[0] == OUT_L1_HO) |=> (pin_o[0] == $past(status_i.l1_mode[BIT_HO])))
    else $error("loop 1 holdover not mirrored");

  a_l1_hist_upd:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (pin_code_i[0] == OUT_L1_HU) |=> (pin_o[0] == $past(status_i.hist_evt_b[BIT_HU])))
    else $error("loop 1 history update not mirrored");

  a_l1_demap:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (pin_code_i[0] == OUT_L1_DM) |=> (pin_o[0] == $past(status_i.l1_hist[BIT_DM13])))
    else $error("loop 1 demap clamp not mirrored");

  a_dist_sync:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (pin_code_i[0] == OUT_L3_SY) ##1 (pin_code_i[0] == OUT_L3_SY)
        |-> (pin_o[0] == $past(status_i.dist_sync[3])) ##1 (pin_o[0] == $past(status_i.dist_sync[3])))
    else $error("loop 3 sync pulse not passed through");

  a_l2_cal:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (pin_code_i[0] == OUT_L2_CB) |=> (pin_o[0] == $past(status_i.l2_lock[BIT_CB])))
    else $error("loop 2 calibration busy not mirrored");

  a_l2_active:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (pin_code_i[0] == OUT_L2_AC && status_i.ref_status[3][BIT_ACT_L2]) |=> pin_o[0])
    else $error("loop 2 active missed reference d");

  a_l2_switch:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (pin_code_i[0] == OUT_L2_SW) |=> (pin_o[0] == $past(status_i.l2_mode[BIT_SW])))
    else $error("loop 2 switchover not mirrored");

  a_l2_demap:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (pin_code_i[0] == OUT_L2_DM) |=> (pin_o[0] == $past(status_i.l2_hist[BIT_DM2])))
    else $error("loop 2 demap clamp not mirrored");

  a_l3_lock:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (pin_code_i[0] == OUT_L3_PL) |=> (pin_o[0] == $past(status_i.l3_lock[BIT_PL])))
    else $error("loop 3 phase lock not mirrored");

  a_l3_active:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (pin_code_i[0] == OUT_L3_AC && status_i.ref_status[3:0] == '0) |=> !pin_o[0])
    else $error("loop 3 active without any reference");

  a_l3_flags:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (pin_code_i[0] == OUT_L3_SL) |=> (pin_o[0] == $past(status_i.l3_hist[BIT_SL])))
    else $error("loop 3 slew limit not mirrored");

  a_io_update:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
      !pin_i[0] ##1 (pin_i[0] && pin_code_i[0] == IN_IO_UPD)
        ##1 (pin_code_i[0] == IN_IO_UPD) [*2] |=> ctrl_o.io_update)
    else $error("pin edge did not strobe register update");

  a_wdog_clear:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (rise[0] && pin_code_i[0] == IN_WDOG_CLR) |=> ctrl_o.wdog_clear)
    else $error("watchdog clear pulse missing");

  a_tmo_ref_a:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (rise[0] && pin_code_i[0] == IN_TMO_A) |=> ctrl_o.force_timeout[3])
    else $error("reference a timeout on wrong bit");

  a_l0_holdover:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (rise[0] && pin_code_i[0] == IN_L0_HO) |=> (ctrl_o.loop0_holdover && !$past(ctrl_o.loop0_holdover)))
    else $error("loop 0 holdover pulse missing");

  a_l0_phase:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (rise[0] && pin_code_i[0] == IN_L0_DEC) |=> ctrl_o.loop0_phase_dec)
    else $error("loop 0 phase decrement missing");

  a_quiet_reserved:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (pin_code_i[0] == OUT_RSVD) |=> !pin_o[0])
    else $error("reserved code drove a pin");

  a_ctrl_from_edge:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
      (rise == '0) |=> (ctrl_o == CTRL_RESET))
    else $error("control pulse without a pin edge");
endmodule

// [bench/mfpm_board.sv]
// mfpm_board: board side of the multifunction pins, resolving each shared wire
`timescale 1ns/1ps
module mfpm_board #(
  parameter int N = 4
) (
  input wire logic [N-1:0] pin_val_i,
  input wire logic [N-1:0] pin_oe_i,
  input wire logic [N-1:0] drive_i,
  output logic [N-1:0] pin_level_o
);
  // pull-down on every pin: a released wire reads low, never its last value
  // board logic drives a pin only while the device leaves it as input
  // the bench holds each assertion for whole cycles and low between them
  assign pin_level_o = (pin_oe_i & pin_val_i) | (~pin_oe_i & drive_i);
endmodule

// [bench/mfpm_top_test.sv]
// mfpm_top_test: self-checking bench for the multifunction pin map
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin fail_count++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, gt); end end
module mfpm_top_test;
  import mfpm_pkg::*;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0][7:0] pin_code = '0;
  logic [3:0] drive = '0;
  logic [3:0] pin_level;
  mfpm_status_t status = '0;
  logic [3:0] pin_o;
  logic [3:0] pin_oe_o;
  mfpm_ctrl_t ctrl_o;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;

  mfpm_top #(.N(4)) mfpm_top_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .pin_code_i(pin_code),
    .pin_i(pin_level), .status_i(status), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .ctrl_o(ctrl_o));
  mfpm_board #(.N(4)) mfpm_board_inst (.pin_val_i(pin_o), .pin_oe_i(pin_oe_o), .drive_i(drive),
    .pin_level_o(pin_level));

  initial begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  // whole run is near 1860 cycles; the ceiling leaves ample margin
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 8000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task report_and_stop;
    if (fail_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // status with only the source bit of an output code set
  function automatic mfpm_status_t src_of(input logic [7:0] c, input int r, output bit has);
    mfpm_status_t s;
    s = '0;
    has = 1'b1;
    case (c)
      8'hD5, 8'hD6, 8'hD7: s.l1_mode[c - 8'hD5] = 1'b1;
      8'hD9: s.hist_evt_b[4] = 1'b1;
      8'hD8: s.l1_hist[0] = 1'b1;
      8'hDA, 8'hDB: s.l1_hist[c - 8'hD9] = 1'b1;
      8'hDD: s.l1_hist[3] = 1'b1;
      8'hDC: s.dist_sync[1] = 1'b1;
      8'hEC: s.dist_sync[2] = 1'b1;
      8'hFC: s.dist_sync[3] = 1'b1;
      8'hE0, 8'hE1, 8'hE2, 8'hE3: s.l2_lock[c - 8'hDF] = 1'b1;
      8'hE4: s.ref_status[r][6] = 1'b1;
      8'hE5, 8'hE6, 8'hE7: s.l2_mode[c - 8'hE5] = 1'b1;
      8'hE8: s.l2_hist[0] = 1'b1;
      8'hEA, 8'hEB: s.l2_hist[c - 8'hE9] = 1'b1;
      8'hED: s.l2_hist[4] = 1'b1;
      8'hE9: s.hist_evt_a[4] = 1'b1;
      8'hF0, 8'hF1, 8'hF2, 8'hF3: s.l3_lock[c - 8'hEF] = 1'b1;
      8'hF4: s.ref_status[r][7] = 1'b1;
      8'hF5, 8'hF6, 8'hF7: s.l3_mode[c - 8'hF5] = 1'b1;
      8'hF8: s.l3_hist[0] = 1'b1;
      8'hFA, 8'hFB: s.l3_hist[c - 8'hF9] = 1'b1;
      8'hFD: s.l3_hist[3] = 1'b1;
      8'hF9: s.hist_evt_b[4] = 1'b1;
      default: has = 1'b0;
    endcase
    return s;
  endfunction

  // control pulse expected from an input code
  function automatic mfpm_ctrl_t ctrl_of(input logic [7:0] c);
    mfpm_ctrl_t x;
    x = '0;
    case (c)
      8'h01: x.io_update = 1'b1;
      8'h02: x.full_power_down = 1'b1;
      8'h03: x.wdog_clear = 1'b1;
      8'h04: x.soft_sync_all = 1'b1;
      8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15: x.irq_clear[c - 8'h10] = 1'b1;
      8'h20, 8'h21, 8'h22, 8'h23: x.force_fault[8'h23 - c] = 1'b1;
      8'h28, 8'h29, 8'h2A, 8'h2B: x.force_timeout[8'h2B - c] = 1'b1;
      8'h40: x.loop0_power_down = 1'b1;
      8'h41: x.loop0_freerun = 1'b1;
      8'h42: x.loop0_holdover = 1'b1;
      8'h43: x.loop0_hist_reset = 1'b1;
      8'h44: x.loop0_phase_inc = 1'b1;
      8'h45: x.loop0_phase_dec = 1'b1;
      8'h46: x.loop0_phase_reset = 1'b1;
      8'h48: x.analog0_soft_sync = 1'b1;
      default: x = '0;
    endcase
    return x;
  endfunction

  // every output code but 83 on pin 0: source bit alone high, then every other bit high except watchdog expiry (and reference status for E4, F4)
  task automatic out_codes;
    mfpm_status_t s;
    bit has;
    for (int c = 8'h80; c <= 8'hFF; c++) begin
      if (c == 8'h83)
        continue;
      s = src_of(c[7:0], c[4] ? 1 : 3, has);
      @(negedge ref_clk_i);
      pin_code[0] = c[7:0];
      status = s;
      @(negedge ref_clk_i);
      if (has)
        `CHK("status pin high", 1'b1, pin_o[0])
      status = ~s;
      // a strobe left running would spill into the watchdog test
      status.wdog_expire = 1'b0;
      // the other references would keep the active flag high
      if (c == 8'hE4 || c == 8'hF4)
        status.ref_status = '0;
      @(negedge ref_clk_i);
      `CHK("status pin low", 1'b0, pin_o[0])
      `CHK("output enables", 4'b0001, pin_oe_o)
    end
    status = '0;
  endtask

  // expiry at iteration 0 and at gap; strobe length counted on the pin
  task automatic wdog_run(input int gap, input int exp_len);
    int cnt;
    cnt = 0;
    @(negedge ref_clk_i);
    pin_code[0] = 8'h83;
    for (int i = 0; i < 80; i++) begin
      @(negedge ref_clk_i);
      status.wdog_expire = (i == 0 || i == gap);
      if (pin_o[0] === 1'b1)
        cnt++;
    end
    `CHK("strobe length", exp_len, cnt)
  endtask

  // pulse the pins in mask with one code and watch the control outputs
  task automatic in_run(input logic [3:0] mask, input logic [7:0] c, input mfpm_ctrl_t ex);
    int hit_at;
    int bad;
    hit_at = -1;
    bad = 0;
    @(negedge ref_clk_i);
    for (int k = 0; k < 4; k++)
      if (mask[k])
        pin_code[k] = c;
    @(negedge ref_clk_i);
    drive = mask;
    for (int i = 0; i < 8; i++) begin
      @(negedge ref_clk_i);
      if (i == 3)
        drive = '0;
      if (ctrl_o !== '0) begin
        if (ctrl_o === ex && hit_at < 0)
          hit_at = i;
        else
          bad++;
      end
    end
    `CHK("control pulse cycle", (ex !== '0) ? 2 : -1, hit_at)
    `CHK("stray control", 0, bad)
    `CHK("input pin enable", 4'b0000, pin_oe_o & mask)
  endtask

  task automatic reset_mid;
    @(negedge ref_clk_i);
    pin_code[0] = 8'hD5;
    status.l1_mode = 8'hFF;
    @(negedge ref_clk_i);
    `CHK("pin before reset", 1'b1, pin_o[0])
    reset_i = 1'b1;
    @(negedge ref_clk_i);
    `CHK("pins in reset", 4'b0000, pin_o)
    `CHK("enables in reset", 4'b0000, pin_oe_o)
    repeat (3) @(negedge ref_clk_i);
    reset_i = 1'b0;
    @(negedge ref_clk_i);
    `CHK("pin after reset", 1'b1, pin_o[0])
    `CHK("enable after reset", 4'b0001, pin_oe_o)
    `CHK("no pulse after reset", mfpm_ctrl_t'('0), ctrl_o)
    status = '0;
  endtask

  initial begin
    repeat (20) @(negedge ref_clk_i);
    `CHK("reset pins", 4'b0000, pin_o)
    `CHK("reset enables", 4'b0000, pin_oe_o)
    `CHK("reset controls", mfpm_ctrl_t'('0), ctrl_o)
    reset_i = 1'b0;
    out_codes();
    wdog_run(0, WDOG_STROBE_CYCLES);
    wdog_run(10, WDOG_STROBE_CYCLES + 10);
    for (int c = 0; c < 128; c++)
      in_run(4'b0001, c[7:0], ctrl_of(c[7:0]));
    // two pins on one code in the same cycle merge into a single pulse
    in_run(4'b0110, 8'h01, ctrl_of(8'h01));
    reset_mid();
    report_and_stop();
  end
endmodule
